// ==== pa_pfc_pkg.sv ====
/*
 * Constants, register map and carrier types for the port A pin function
 * select block. Assumes a 32-bit APB4 register bus, with the block's
 * registers decoded from the low twelve bits of the byte address.
 */
`default_nettype none

package pa_pfc_pkg;

    // Bus widths and register count.
    localparam int ADDR_W   = 12;
    localparam int DATA_W   = 32;
    localparam int NUM_REGS = 13;
    localparam int PINS     = 16;

    // Printed register offsets, kept as register indices; byte address is four times each.
    localparam logic [31:0] IDX_PORT_A_DIRECTION     = 32'hffff8386;
    localparam logic [31:0] IDX_PORT_A_FUNCTION_HIGH = 32'hffff838c;
    localparam logic [31:0] IDX_PORT_A_FUNCTION_LOW  = 32'hffff838e;
    localparam logic [31:0] IDX_PORT_B_DIRECTION     = 32'hffff8394;
    localparam logic [31:0] IDX_PORT_C_DIRECTION     = 32'hffff8396;
    localparam logic [31:0] IDX_PORT_B_FUNCTION_ONE  = 32'hffff8398;
    localparam logic [31:0] IDX_PORT_B_FUNCTION_TWO  = 32'hffff839a;
    localparam logic [31:0] IDX_PORT_C_FUNCTION      = 32'hffff839c;
    localparam logic [31:0] IDX_PORT_D_DIRECTION     = 32'hffff83a6;
    localparam logic [31:0] IDX_PORT_D_FUNCTION      = 32'hffff83ac;
    localparam logic [31:0] IDX_PORT_E_DIRECTION     = 32'hffff83b4;
    localparam logic [31:0] IDX_PORT_E_FUNCTION_ONE  = 32'hffff83b8;
    localparam logic [31:0] IDX_PORT_E_FUNCTION_TWO  = 32'hffff83ba;

    // Storage slots, in the order of the index table below.
    localparam logic [3:0] SLOT_DIR = 4'h0;
    localparam logic [3:0] SLOT_HI  = 4'h1;
    localparam logic [3:0] SLOT_LO  = 4'h2;

    localparam logic [31:0] IDX_TABLE [NUM_REGS] = '{
        IDX_PORT_A_DIRECTION, IDX_PORT_A_FUNCTION_HIGH, IDX_PORT_A_FUNCTION_LOW,
        IDX_PORT_B_DIRECTION, IDX_PORT_C_DIRECTION, IDX_PORT_B_FUNCTION_ONE,
        IDX_PORT_B_FUNCTION_TWO, IDX_PORT_C_FUNCTION, IDX_PORT_D_DIRECTION,
        IDX_PORT_D_FUNCTION, IDX_PORT_E_DIRECTION, IDX_PORT_E_FUNCTION_ONE,
        IDX_PORT_E_FUNCTION_TWO
    };

    // Reset values.
    localparam logic [15:0] RST_DIR     = 16'h0000;
    localparam logic [15:0] RST_HI      = 16'h0000;
    localparam logic [15:0] RST_HI_EXT  = 16'h4000;
    localparam logic [15:0] RST_LO      = 16'h0000;
    localparam logic [15:0] RST_OTHER   = 16'h0000;

    // Writable bits, full variant and reduced-pin variant.
    localparam logic [15:0] MASK_DIR     = 16'hffff;
    localparam logic [15:0] MASK_DIR_RED = 16'h83ff;
    localparam logic [15:0] MASK_HI      = 16'h555f;
    localparam logic [15:0] MASK_HI_RED  = 16'h400f;
    localparam logic [15:0] MASK_LO      = 16'hfd75;
    localparam logic [15:0] MASK_OTHER   = 16'hffff;

    // Field positions in the high-half function register.
    localparam int HI_CLK_OUT   = 14;
    localparam int HI_READ      = 12;
    localparam int HI_WR_UPPER  = 10;
    localparam int HI_WR_LOWER  = 8;
    localparam int HI_CS_ONE    = 6;
    localparam int HI_CS_ZERO   = 4;
    localparam int HI_PIN9_LSB  = 2;
    localparam int HI_PIN8_LSB  = 0;

    // Field positions in the low-half function register.
    localparam int LO_PIN7_LSB  = 14;
    localparam int LO_PIN6_LSB  = 12;
    localparam int LO_PIN5_LSB  = 10;
    localparam int LO_PIN4      = 8;
    localparam int LO_PIN3      = 6;
    localparam int LO_PIN2_LSB  = 4;
    localparam int LO_PIN1      = 2;
    localparam int LO_PIN0      = 0;

    // Two-bit field codes.
    localparam logic [1:0] FLD_GPIO  = 2'h0;
    localparam logic [1:0] FLD_SEL_A = 2'h1;
    localparam logic [1:0] FLD_SEL_B = 2'h2;
    localparam logic [1:0] FLD_SEL_C = 2'h3;

    // What drives and reads a pin.
    typedef enum logic [1:0] {
        PA_FN_GPIO  = 2'b00,
        PA_FN_OUT   = 2'b01,
        PA_FN_IN    = 2'b10,
        PA_FN_BIDIR = 2'b11
    } pa_fn_t;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0]        pstrb;
    } pa_apb_req_t;

    typedef struct packed {
        logic              pready;
        logic [DATA_W-1:0] prdata;
        logic              pslverr;
    } pa_apb_rsp_t;

    typedef struct packed {
        logic single_chip;
        logic rom_invalid;
        logic extended;
        logic reduced;
    } pa_mode_t;

    typedef struct packed {
        logic [PINS-1:0] out;
        logic [PINS-1:0] oe;
    } pa_pads_t;

    typedef struct packed {
        logic [3:0] timer_clk;
        logic [3:0] irq;
        logic [1:0] transfer_req;
        logic [1:0] rx_data;
        logic [1:0] serial_clk;
    } pa_func_in_t;

endpackage : pa_pfc_pkg

`default_nettype wire

// ==== pa_pfc_props.sv ====
/* Assertion checker for pa_pfc_top, fed only by the top module's ports.
   Assumes straps change only under reset and software writes aligned words. */
`timescale 1ns/1ps
`default_nettype none
module pa_pfc_props
    import pa_pfc_pkg::*;
(
    // Clock and reset.
    input wire logic        ref_clk,
    input wire logic        srst,
    // Bus and straps.
    input wire pa_apb_req_t apb_req,
    input wire pa_apb_rsp_t apb_rsp,
    input wire pa_mode_t    mode,
    // Pin side.
    input wire logic [15:0] gpio_out,
    input wire logic [15:0] gpio_in,
    input wire logic [15:0] func_out,
    input wire pa_func_in_t func_in,
    input wire logic [15:0] pad_in,
    input wire pa_pads_t    pads
);
    logic [15:0] hi_r;
    logic [15:0] dir_r;
    // Bus decode for the two shadowed registers.
    wire logic        acc   = apb_req.psel && apb_req.penable;
    wire logic        wr    = acc && apb_req.pwrite;
    wire logic        rdx   = acc && !apb_req.pwrite;
    wire logic [15:0] lanes = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};
    wire logic [15:0] hi_m  = lanes & (mode.reduced ? MASK_HI_RED : MASK_HI);
    wire logic [15:0] dir_m = lanes & (mode.reduced ? MASK_DIR_RED : MASK_DIR);
    wire logic [15:0] wd    = apb_req.pwdata[15:0];
    wire logic        free  = !mode.single_chip && !mode.rom_invalid && !mode.reduced;

    // Shadows let pin behaviour be tied to the bus writes that caused it.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            hi_r  <= mode.extended ? RST_HI_EXT : RST_HI;
            dir_r <= RST_DIR;
        end else if (wr && apb_req.paddr == 12'he30) begin
            hi_r <= (hi_r & ~hi_m) | (wd & hi_m);
        end else if (wr && apb_req.paddr == 12'he18) begin
            dir_r <= (dir_r & ~dir_m) | (wd & dir_m);
        end
    end

    // Checks start one edge after reset is sampled low. The disable term reads
    // current values, so an attempt could otherwise begin on the releasing edge
    // and judge pads that the reset still holds at zero.
    logic run_r;
    always_ff @(posedge ref_clk) begin
        run_r <= !srst;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst || !run_r);

    pads_rst_a: assert property (disable iff (1'b0)
        srst |=> pads == '0 && func_in == '0)
        else $error("outputs not idle after reset");
    hi_read_a: assert property (
        rdx && apb_req.paddr == 12'he30 |-> apb_rsp.prdata == {16'h0, hi_r})
        else $error("function high readback wrong");
    dir_read_a: assert property (
        rdx && apb_req.paddr == 12'he18 |-> apb_rsp.prdata == {16'h0, dir_r})
        else $error("direction readback wrong");
    clk_out_a: assert property (
        hi_r[14] |=> pads.oe[15] && pads.out[15] == $past(func_out[15]))
        else $error("pin 15 not on clock output");
    pin15_gpio_a: assert property (
        !hi_r[14] |=> pads.oe[15] == $past(dir_r[15])
                      && pads.out[15] == $past(gpio_out[15]))
        else $error("pin 15 not general io");
    rd_force_a: assert property (
        mode.rom_invalid && !mode.reduced
            |=> pads.oe[14] && pads.out[14] == $past(func_out[14]))
        else $error("read strobe not forced");
    single_io_a: assert property (
        mode.single_chip && !mode.rom_invalid && !mode.reduced
            |=> pads.oe[14:11] == $past(dir_r[14:11]))
        else $error("bus pins not general io");
    wr_upper_a: assert property (
        free && hi_r[10] |=> pads.oe[13] && pads.out[13] == $past(func_out[13]))
        else $error("upper write strobe not routed");
    timer9_a: assert property (
        hi_r[3:2] == 2'b01 |=> func_in.timer_clk[3] == $past(pad_in[9]))
        else $error("pin 9 timer input not routed");

    // Main scenarios reached.
    cover property (wr && apb_req.paddr == 12'he30);
    cover property (acc && apb_rsp.pslverr);
    cover property (hi_r[3:2] == 2'b10);
endmodule : pa_pfc_props
`default_nettype wire

// ==== pa_pfc_top.sv ====
/*
 * Port A pin function select: direction and function registers, the pin
 * multiplexer for sixteen port A pins, and plain storage for the port B to E
 * direction and function registers. Assumes srst is the external power-on
 * reset only; watchdog reset, standby and sleep never reach it. Mode straps
 * are steady while the block runs. Pads are resolved by the surroundings
 * from out and oe.
 */
`timescale 1ns/1ps
`default_nettype none

module pa_pfc_top
    import pa_pfc_pkg::*;
(
    // Clock and power-on reset.
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // Register bus.
    input  wire pa_apb_req_t apb_req,
    output var  pa_apb_rsp_t apb_rsp,
    // Operating mode straps.
    input  wire pa_mode_t    mode,
    // Port latch side.
    input  wire logic [15:0] gpio_out,
    output var  logic [15:0] gpio_in,
    // Peripheral side, one output per pin position.
    input  wire logic [15:0] func_out,
    output var  pa_func_in_t func_in,
    // Pads.
    input  wire logic [15:0] pad_in,
    output var  pa_pads_t    pads
);

    // Maps a bus address onto a storage slot; hit is low for unmapped words.
    function automatic logic [4:0] decode(input logic [ADDR_W-1:0] addr);
        logic [4:0] res;
        res = 5'h00;
        for (int k = 0; k < NUM_REGS; k++) begin
            if (addr[ADDR_W-1:2] == IDX_TABLE[k][ADDR_W-3:0]) begin
                res = {1'b1, 4'(k)};
            end
        end
        return res;
    endfunction : decode

    // Writable bits of a slot, which also decide what reads back.
    function automatic logic [15:0] wr_mask(input logic [3:0] slot, input logic reduced);
        logic [15:0] m;
        m = MASK_OTHER;
        if (slot == SLOT_DIR) begin
            m = reduced ? MASK_DIR_RED : MASK_DIR;
        end else if (slot == SLOT_HI) begin
            m = reduced ? MASK_HI_RED : MASK_HI;
        end else if (slot == SLOT_LO) begin
            m = MASK_LO;
        end
        return m;
    endfunction : wr_mask

    // Single-bit bus pin selection with the mode overrides.
    function automatic logic bus_pin(input logic sel, input pa_mode_t m);
        logic r;
        r = m.rom_invalid ? 1'b1 : (m.single_chip ? 1'b0 : sel);
        return m.reduced ? 1'b0 : r;
    endfunction : bus_pin

    // Class of a two-bit field; codes 1 to 3 take the classes given by the caller, code 0 is general I/O.
    function automatic pa_fn_t fld_cls(input logic [1:0] f, input pa_fn_t ca,
                                       input pa_fn_t cb, input pa_fn_t cc);
        pa_fn_t r;
        case (f)
            FLD_SEL_A: r = ca;
            FLD_SEL_B: r = cb;
            FLD_SEL_C: r = cc;
            default:   r = PA_FN_GPIO;
        endcase
        return r;
    endfunction : fld_cls

    // Register storage, one word per slot.
    logic [15:0] reg_r   [NUM_REGS];
    logic [31:0] rdata_r;
    pa_pads_t    pads_r;
    pa_func_in_t fin_r;
    logic [15:0] gin_r;

    // Bus decode.
    wire logic [4:0]  dec       = decode(apb_req.paddr);
    wire logic        hit       = dec[4];
    wire logic [3:0]  slot      = dec[3:0];
    wire logic        setup     = apb_req.psel & ~apb_req.penable;
    wire logic        access    = apb_req.psel & apb_req.penable;
    wire logic        wr_go     = access & apb_req.pwrite & hit;
    wire logic [15:0] lane_mask = {{8{apb_req.pstrb[1]}}, {8{apb_req.pstrb[0]}}};
    wire logic [15:0] slot_mask = wr_mask(slot, mode.reduced);
    wire logic [15:0] wr_val    = ((reg_r[slot] & ~lane_mask)
                                   | (apb_req.pwdata[15:0] & lane_mask)) & slot_mask;
    wire logic [15:0] rd_val    = reg_r[slot] & slot_mask;

    // Zero-wait slave; unmapped words answer with an error and read as zero.
    assign apb_rsp.pready  = 1'b1;
    assign apb_rsp.prdata  = rdata_r;
    assign apb_rsp.pslverr = access & ~hit;

    // Read data is captured in the setup cycle so that it leaves a flip-flop.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rdata_r <= 32'h0000_0000;
        end else if (setup) begin
            rdata_r <= hit ? {16'h0000, rd_val} : 32'h0000_0000;
        end
    end

    // Only power-on reset touches the registers; nothing else here clears them.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            for (int k = 0; k < NUM_REGS; k++) begin
                reg_r[k] <= RST_OTHER;
            end
            reg_r[SLOT_DIR] <= RST_DIR;
            reg_r[SLOT_HI]  <= mode.extended ? RST_HI_EXT : RST_HI;
            reg_r[SLOT_LO]  <= RST_LO;
        end else if (wr_go) begin
            reg_r[slot] <= wr_val;
        end
    end

    // Effective register contents; bits absent in this variant read and act as zero.
    wire logic [15:0] dir = reg_r[SLOT_DIR] & wr_mask(SLOT_DIR, mode.reduced);
    wire logic [15:0] hi  = reg_r[SLOT_HI] & wr_mask(SLOT_HI, mode.reduced);
    wire logic [15:0] lo  = reg_r[SLOT_LO] & MASK_LO;

    // Classes that depend on single-chip mode for chip selects and transfer requests.
    wire pa_fn_t cs_hi_cls  = mode.single_chip ? PA_FN_GPIO : PA_FN_OUT;
    wire pa_fn_t req_cls    = mode.single_chip ? PA_FN_GPIO : PA_FN_IN;

    // Per-pin function classes for the high half.
    pa_fn_t cls [PINS];
    assign cls[15] = hi[HI_CLK_OUT] ? PA_FN_OUT : PA_FN_GPIO;
    assign cls[14] = bus_pin(hi[HI_READ], mode) ? PA_FN_OUT : PA_FN_GPIO;
    assign cls[13] = bus_pin(hi[HI_WR_UPPER], mode) ? PA_FN_OUT : PA_FN_GPIO;
    assign cls[12] = bus_pin(hi[HI_WR_LOWER], mode) ? PA_FN_OUT : PA_FN_GPIO;
    assign cls[11] = bus_pin(hi[HI_CS_ONE], mode) ? PA_FN_OUT : PA_FN_GPIO;
    assign cls[10] = bus_pin(hi[HI_CS_ZERO], mode) ? PA_FN_OUT : PA_FN_GPIO;
    // The reserved code leaves the pin as general I/O.
    assign cls[9]  = fld_cls(hi[HI_PIN9_LSB +: 2], PA_FN_IN, PA_FN_IN, PA_FN_GPIO);
    assign cls[8]  = fld_cls(hi[HI_PIN8_LSB +: 2], PA_FN_IN, PA_FN_IN, PA_FN_GPIO);

    // Per-pin function classes for the low half.
    assign cls[7]  = fld_cls(lo[LO_PIN7_LSB +: 2], PA_FN_IN, cs_hi_cls, PA_FN_GPIO);
    assign cls[6]  = fld_cls(lo[LO_PIN6_LSB +: 2], PA_FN_IN, cs_hi_cls, PA_FN_GPIO);
    assign cls[5]  = fld_cls(lo[LO_PIN5_LSB +: 2], PA_FN_BIDIR, req_cls, PA_FN_IN);
    assign cls[4]  = lo[LO_PIN4] ? PA_FN_OUT : PA_FN_GPIO;
    assign cls[3]  = lo[LO_PIN3] ? PA_FN_IN : PA_FN_GPIO;
    assign cls[2]  = fld_cls(lo[LO_PIN2_LSB +: 2], PA_FN_BIDIR, req_cls, PA_FN_IN);
    assign cls[1]  = lo[LO_PIN1] ? PA_FN_OUT : PA_FN_GPIO;
    assign cls[0]  = lo[LO_PIN0] ? PA_FN_IN : PA_FN_GPIO;

    // Pad drive: the latch feeds general I/O pins, the peripheral every other pin.
    logic [15:0] pad_out_nxt;
    logic [15:0] pad_oe_nxt;
    logic [15:0] gin_nxt;
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            pad_out_nxt[i] = (cls[i] == PA_FN_GPIO) ? gpio_out[i] : func_out[i];
            case (cls[i])
                PA_FN_GPIO, PA_FN_BIDIR: pad_oe_nxt[i] = dir[i];
                PA_FN_OUT:               pad_oe_nxt[i] = 1'b1;
                default:                 pad_oe_nxt[i] = 1'b0;
            endcase
            gin_nxt[i] = (cls[i] == PA_FN_GPIO) ? pad_in[i] : 1'b0;
        end
    end

    // Peripheral inputs see their pin only while that function owns it.
    pa_func_in_t fin_nxt;
    assign fin_nxt.timer_clk = {
        (cls[9] == PA_FN_IN) && (hi[HI_PIN9_LSB +: 2] == FLD_SEL_A) && pad_in[9],
        (cls[8] == PA_FN_IN) && (hi[HI_PIN8_LSB +: 2] == FLD_SEL_A) && pad_in[8],
        (cls[7] == PA_FN_IN) && pad_in[7],
        (cls[6] == PA_FN_IN) && pad_in[6]
    };
    assign fin_nxt.irq = {
        (hi[HI_PIN9_LSB +: 2] == FLD_SEL_B) && pad_in[9],
        (hi[HI_PIN8_LSB +: 2] == FLD_SEL_B) && pad_in[8],
        (lo[LO_PIN5_LSB +: 2] == FLD_SEL_C) && pad_in[5],
        (lo[LO_PIN2_LSB +: 2] == FLD_SEL_C) && pad_in[2]
    };
    assign fin_nxt.transfer_req = {
        (lo[LO_PIN5_LSB +: 2] == FLD_SEL_B) && (cls[5] == PA_FN_IN) && pad_in[5],
        (lo[LO_PIN2_LSB +: 2] == FLD_SEL_B) && (cls[2] == PA_FN_IN) && pad_in[2]
    };
    assign fin_nxt.rx_data = {
        (cls[3] == PA_FN_IN) && pad_in[3],
        (cls[0] == PA_FN_IN) && pad_in[0]
    };
    assign fin_nxt.serial_clk = {
        (cls[5] == PA_FN_BIDIR) && pad_in[5],
        (cls[2] == PA_FN_BIDIR) && pad_in[2]
    };

    // Pin-side outputs are registered; this costs one cycle of latency on every
    // path through the mux but keeps glitches from the decode off the pads.
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pads_r <= '0;
            fin_r  <= '0;
            gin_r  <= 16'h0000;
        end else begin
            pads_r <= '{out: pad_out_nxt, oe: pad_oe_nxt};
            fin_r  <= fin_nxt;
            gin_r  <= gin_nxt;
        end
    end

    assign pads    = pads_r;
    assign func_in = fin_r;
    assign gpio_in = gin_r;

endmodule : pa_pfc_top

`default_nettype wire

// ==== pa_pfc_top_tb.sv ====
/* Self-checking bench for pa_pfc_top: reset values, register map, pin routing.
   Assumes the package and checker files are compiled before this one. */
`timescale 1ns/1ps
`default_nettype none
module pa_pfc_top_tb;
    import pa_pfc_pkg::*;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    pa_apb_req_t apb_req = '0;
    pa_apb_rsp_t apb_rsp;
    pa_mode_t    mode = '0;
    logic [15:0] gpio_out = '0;
    logic [15:0] gpio_in;
    logic [15:0] func_out = '0;
    pa_func_in_t func_in;
    logic [15:0] pad_in = '0;
    pa_pads_t    pads;
    int          mismatches = 0;
    int          compares = 0;
    logic [31:0] rd;
    logic        er;

    // Free-running 250 MHz clock.
    always #2 ref_clk = ~ref_clk;

    pa_pfc_top pa_pfc_top_inst (.ref_clk(ref_clk), .srst(srst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .mode(mode), .gpio_out(gpio_out), .gpio_in(gpio_in),
        .func_out(func_out), .func_in(func_in), .pad_in(pad_in), .pads(pads));

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Straps only move under reset, since the design treats them as steady.
    task automatic do_reset(input pa_mode_t m);
        @(posedge ref_clk);
        srst <= 1'b1;
        mode <= m;
        repeat (8) @(posedge ref_clk);
        srst <= 1'b0;
    endtask : do_reset

    // One APB transfer; the wait for ready is bounded so a hang ends the run.
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
        int n;
        @(posedge ref_clk);
        apb_req <= '{1'b1, 1'b0, w, a, {16'h0, d}, 4'h3};
        @(posedge ref_clk);
        apb_req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (apb_rsp.pready !== 1'b1 && n < 16);
        if (n >= 16) begin
            mismatches++;
            $display("MISMATCH t=%0t no ready from the register bus", $time);
            final_report();
        end
        rd = apb_rsp.prdata;
        er = apb_rsp.pslverr;
        apb_req.psel    <= 1'b0;
        apb_req.penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
        apb(1'b0, a, 16'h0);
        chk(rd, {16'h0, exp}, "register read");
    endtask : rd_chk

    // Pads follow a register write one edge later; three edges leave margin.
    task automatic settle();
        repeat (3) @(posedge ref_clk);
    endtask : settle

    task automatic t_reset();
        do_reset(pa_mode_t'(4'b0010));
        rd_chk(12'he30, 16'h4000);
        rd_chk(12'he18, 16'h0000);
        rd_chk(12'he38, 16'h0000);
        do_reset(pa_mode_t'(4'b0000));
        rd_chk(12'he30, 16'h0000);
    endtask : t_reset

    task automatic t_regs();
        logic [11:0] adr [5] = '{12'he18, 12'he30, 12'he38, 12'he50, 12'hee8};
        logic [15:0] exp [5] = '{16'hffff, 16'h555f, 16'hfd75, 16'hffff, 16'hffff};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, adr[i], 16'hffff);
            rd_chk(adr[i], exp[i]);
        end
        apb(1'b1, 12'hffc, 16'hffff);
        chk(32'(er), 32'h1, "unmapped error");
        rd_chk(12'hffc, 16'h0000);
        do_reset(pa_mode_t'(4'b0001));
        apb(1'b1, 12'he18, 16'hffff);
        rd_chk(12'he18, 16'h83ff);
        apb(1'b1, 12'he30, 16'hffff);
        rd_chk(12'he30, 16'h400f);
        do_reset(pa_mode_t'(4'b0000));
    endtask : t_regs

    task automatic t_pins();
        logic [2:0] pexp;
        logic [2:0] pgot;
        func_out <= 16'ha800;
        gpio_out <= 16'h0000;
        apb(1'b1, 12'he30, 16'h4540);
        settle();
        chk(32'({pads.oe[15], pads.out[15]}), 32'h3, "clock out");
        chk(32'(pads.oe[13:11]), 32'h7, "strobe enables");
        chk(32'(pads.out[13:11]), 32'h5, "strobe levels");
        gpio_out <= 16'h0000;
        apb(1'b1, 12'he30, 16'h0000);
        apb(1'b1, 12'he18, 16'h8000);
        settle();
        chk(32'({pads.oe[15], pads.out[15], pads.oe[13]}), 32'h4, "pin 15 io");
        for (int c = 0; c < 4; c++) begin
            pad_in <= 16'h0200;
            apb(1'b1, 12'he30, 16'(c << 2));
            settle();
            pexp = {c == 1, c == 2, c == 0 || c == 3};
            pgot = {func_in.timer_clk[3], func_in.irq[3], gpio_in[9]};
            chk(32'(pgot), 32'(pexp), "pin 9 code");
        end
        // Low half: pin 4 transmit, pin 2 serial clock, pin 0 receive.
        func_out <= 16'h0014;
        pad_in   <= 16'h0001;
        apb(1'b1, 12'he38, 16'h0111);
        apb(1'b1, 12'he18, 16'h0004);
        settle();
        chk(32'({pads.oe[4], pads.out[4]}), 32'h3, "transmit pin");
        chk(32'({pads.oe[2], pads.out[2]}), 32'h3, "serial clock out");
        chk(32'({func_in.rx_data[0], gpio_in[0]}), 32'h2, "receive pin");
        apb(1'b1, 12'he18, 16'h0000);
        settle();
        chk(32'(pads.oe[2]), 32'h0, "serial clock in");
    endtask : t_pins

    task automatic t_modes();
        func_out <= 16'h4000;
        do_reset(pa_mode_t'(4'b0100));
        settle();
        chk(32'({pads.oe[14], pads.out[14]}), 32'h3, "read strobe forced");
        do_reset(pa_mode_t'(4'b1000));
        apb(1'b1, 12'he30, 16'h1540);
        settle();
        chk(32'(pads.oe[14:11]), 32'h0, "single chip io");
    endtask : t_modes

    initial begin
        do_reset(pa_mode_t'(4'b0000));
        t_reset();
        t_regs();
        t_pins();
        t_modes();
        final_report();
    end
endmodule : pa_pfc_top_tb

bind pa_pfc_top pa_pfc_props pa_pfc_props_inst (.ref_clk(ref_clk), .srst(srst),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .mode(mode), .gpio_out(gpio_out),
    .gpio_in(gpio_in), .func_out(func_out), .func_in(func_in), .pad_in(pad_in),
    .pads(pads));
`default_nettype wire
